// >>> design/ioch_host.sv
// I/O channel host controller: cycle engine on the bus clock, request port on the system clock
`timescale 1ns/1ps
`include "ioch_params.svh"
module ioch_host (
	input wire logic clk, // System clock, 50 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic bus_clk, // Bus clock, asynchronous to clk
	input wire logic power_fail, // Power coming up or low line voltage (pin)
	input wire logic req_valid, // Cycle request (level, held until done)
	input wire ioch_pkg::ioch_cmd_t req_cmd, // Cycle kind
	input wire logic [`IOCH_ADDR_W-1:0] req_addr, // Cycle address
	input wire logic [`IOCH_DATA_W-1:0] req_wdata, // Write data
	input wire logic req_wide, // Request a 16-bit transfer
	output logic req_done, // One-cycle pulse: cycle finished
	output logic [`IOCH_DATA_W-1:0] req_rdata, // Read data, valid with req_done
	output logic irq_pending, // Some ranked interrupt request (lines 3-7, 9-13, 15) is pending
	output logic [3:0] irq_vector, // Highest ranked pending interrupt line
	output logic chan_err, // Sticky channel check error
	input wire logic chan_err_clr, // Clear the channel check error
	output logic [2:0] dma_grant_ch, // DMA channel granted
	output logic dma_grant_wide, // Granted channel moves 16-bit words
	output logic dma_active, // A DMA grant is in force
	input wire logic dma_tc_in, // Terminal count reached (pulse, clk)
	input wire logic dma_done, // Current DMA transfer finished (pulse, clk)
	output logic bus_reset, // Bus reset drive
	output logic [`IOCH_SA_W-1:0] sa, // Latched system address
	output logic addr_latch, // Address latch enable
	output logic [`IOCH_DATA_W-1:0] sd_o, // Data out
	output logic sd_oe, // Data out enable
	input wire logic [`IOCH_DATA_W-1:0] sd_i, // Data in
	output logic ior_n, // I/O read strobe
	output logic iow_n, // I/O write strobe
	output logic smemr_n, // Low-meg memory read
	output logic smemw_n, // Low-meg memory write
	output logic memr_n, // Memory read
	output logic memw_n, // Memory write
	output logic refresh_n, // Refresh indication
	output logic sbhe_n, // Upper byte enable
	output logic addr_en, // DMA owns the address bus
	output logic term_count, // Terminal count pulse
	output logic [`IOCH_DMA_CH-1:0] dack_n, // DMA acknowledges
	input wire logic [`IOCH_DMA_CH-1:0] drq, // DMA requests (pins)
	input wire logic [`IOCH_IRQ_N-1:0] irq, // Interrupt requests (pins)
	input wire logic iochrdy, // Channel ready (pin)
	input wire logic iochck_n, // Channel check (pin)
	input wire logic memcs16_n, // Memory 16-bit select (pin)
	input wire logic iocs16_n, // I/O 16-bit select (pin)
	input wire logic zws_n, // Zero wait state (pin)
	input wire logic master_n // External master (pin)
);
	import ioch_pkg::*;

	// Fixed DMA ranking; channel 4 is cascade and never granted
	function automatic logic [3:0] dma_pick(input logic [`IOCH_DMA_CH-1:0] r);
		logic [3:0] p;
		p = {1'b0, `IOCH_DMA_NONE};
		for (int i = `IOCH_DMA_CH - 1; i >= 0; i--)
			if (r[i] && i != 4)
				p = {1'b1, 3'(i)};
		return p;
	endfunction : dma_pick

	// Interrupt ranking, lowest rank scanned first so higher overwrites
	function automatic logic [4:0] irq_pick(input logic [`IOCH_IRQ_N-1:0] r);
		logic [4:0] p;
		p = {1'b0, `IOCH_IRQ_NONE};
		for (int i = 7; i >= 3; i--)
			if (r[i])
				p = {1'b1, 4'(i)};
		if (r[15])
			p = {1'b1, 4'hF};
		for (int i = 13; i >= 9; i--)
			if (r[i])
				p = {1'b1, 4'(i)};
		return p;
	endfunction : irq_pick

	// Bus clock side state
	typedef struct packed {
		ioch_phase_t phase;
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic ack_tog;
		logic rdy_s1;
		logic rdy_s2;
		logic m16_s1;
		logic m16_s2;
		logic i16_s1;
		logic i16_s2;
		logic zws_s1;
		logic zws_s2;
		logic mst_s1;
		logic mst_s2;
		logic dma_s1;
		logic dma_s2;
		logic dma_s3;
		logic rst_s1;
		logic rst_s2;
		logic tc_s1;
		logic tc_s2;
		logic tc_s3;
		logic [2:0] dch_s1;
		logic [2:0] dch_s2;
		logic [2:0] wait_cnt;
		logic [2:0] cmd;
		logic [`IOCH_ADDR_W-1:0] addr;
		logic wide;
		logic [`IOCH_DATA_W-1:0] rdata;
		logic [`IOCH_SA_W-1:0] sa;
		logic ale;
		logic [`IOCH_DATA_W-1:0] sd_o;
		logic sd_oe;
		logic ior_n;
		logic iow_n;
		logic smemr_n;
		logic smemw_n;
		logic memr_n;
		logic memw_n;
		logic refresh_n;
		logic sbhe_n;
		logic aen;
		logic tc;
		logic [`IOCH_DMA_CH-1:0] dack_n;
	} ioch_bus_t;

	ioch_bus_t b, next_b;

	// System clock side state
	typedef struct packed {
		logic [`IOCH_DMA_CH-1:0] drq_s1;
		logic [`IOCH_DMA_CH-1:0] drq_s2;
		logic [`IOCH_IRQ_N-1:0] irq_s1;
		logic [`IOCH_IRQ_N-1:0] irq_s2;
		logic chk_s1;
		logic chk_s2;
		logic pf_s1;
		logic pf_s2;
		logic done_s1;
		logic done_s2;
		logic done_s3;
		logic req_tog;
		logic req_done;
		logic [`IOCH_DATA_W-1:0] rdata;
		logic irq_pending;
		logic [3:0] irq_vector;
		logic chan_err;
		logic [2:0] dma_ch;
		logic dma_wide;
		logic dma_active;
		logic tc_tog;
		logic bus_reset;
		logic busy;
		logic dma_hold;
	} ioch_sys_t;

	ioch_sys_t s, next_s;
	logic [4:0] irq_sel;
	logic [3:0] dma_sel;

	always_comb
	begin
		irq_sel = irq_pick(s.irq_s2);
		dma_sel = dma_pick(s.drq_s2);
	end

	// System side: synchronisers, ranking, request handshake
	always_comb
	begin
		next_s = s;
		next_s.drq_s1 = drq;
		next_s.drq_s2 = s.drq_s1;
		next_s.irq_s1 = irq;
		next_s.irq_s2 = s.irq_s1;
		next_s.chk_s1 = iochck_n;
		next_s.chk_s2 = s.chk_s1;
		next_s.pf_s1 = power_fail;
		next_s.pf_s2 = s.pf_s1;
		next_s.done_s1 = b.ack_tog;
		next_s.done_s2 = s.done_s1;
		next_s.done_s3 = s.done_s2;
		next_s.bus_reset = s.pf_s2;
		next_s.irq_pending = irq_sel[4];
		next_s.irq_vector = irq_sel[3:0];
		// Error set wins over clear
		if (!s.chk_s2)
			next_s.chan_err = 1'b1;
		else if (chan_err_clr)
			next_s.chan_err = 1'b0;
		// Grant held while the request stays up, released on done; the old request is still
		// in the synchroniser after a release, so no new grant until it has dropped
		if (s.dma_hold)
		begin
			if (!s.drq_s2[s.dma_ch])
				next_s.dma_hold = 1'b0;
		end
		else if (!s.dma_active && dma_sel[3])
		begin
			next_s.dma_active = 1'b1;
			next_s.dma_ch = dma_sel[2:0];
			next_s.dma_wide = dma_sel[2];
		end
		else if (s.dma_active && (dma_done || !s.drq_s2[s.dma_ch]))
		begin
			next_s.dma_active = 1'b0;
			next_s.dma_hold = 1'b1;
		end
		if (dma_tc_in)
			next_s.tc_tog = ~s.tc_tog;
		next_s.req_done = 1'b0;
		if (req_valid && !s.busy && !s.req_done)
		begin
			next_s.busy = 1'b1;
			next_s.req_tog = ~s.req_tog;
		end
		else if (s.busy && (s.done_s2 != s.done_s3))
		begin
			next_s.busy = 1'b0;
			next_s.req_done = 1'b1;
			next_s.rdata = b.rdata;
		end
		if (rst)
		begin
			next_s = '0;
			next_s.bus_reset = 1'b1;
			next_s.chk_s1 = 1'b1;
			next_s.chk_s2 = 1'b1;
			next_s.dma_ch = `IOCH_DMA_NONE;
			// Bus reset stays up until a clean power level has passed the synchroniser
			next_s.pf_s1 = 1'b1;
			next_s.pf_s2 = 1'b1;
		end
	end

	always_ff @(posedge clk)
		s <= next_s;

	// Bus side cycle engine, control inputs from clk or pins pass two flops; request fields and sd_i are sampled directly
	always_comb
	begin
		next_b = b;
		next_b.req_s1 = s.req_tog;
		next_b.req_s2 = b.req_s1;
		next_b.rdy_s1 = iochrdy;
		next_b.rdy_s2 = b.rdy_s1;
		next_b.m16_s1 = memcs16_n;
		next_b.m16_s2 = b.m16_s1;
		next_b.i16_s1 = iocs16_n;
		next_b.i16_s2 = b.i16_s1;
		next_b.zws_s1 = zws_n;
		next_b.zws_s2 = b.zws_s1;
		next_b.mst_s1 = master_n;
		next_b.mst_s2 = b.mst_s1;
		next_b.dma_s1 = s.dma_active;
		next_b.dma_s2 = b.dma_s1;
		next_b.dma_s3 = b.dma_s2;
		next_b.dch_s1 = s.dma_ch;
		next_b.dch_s2 = b.dch_s1;
		next_b.rst_s1 = s.bus_reset;
		next_b.rst_s2 = b.rst_s1;
		next_b.tc_s1 = s.tc_tog;
		next_b.tc_s2 = b.tc_s1;
		next_b.tc_s3 = b.tc_s2;
		next_b.tc = (b.tc_s2 != b.tc_s3);
		// DMA ownership of the address bus; the flag is used one stage after the channel word has settled
		next_b.aen = b.dma_s2 && b.dma_s3;
		next_b.dack_n = '1;
		if (b.dma_s2 && b.dma_s3)
			next_b.dack_n[b.dch_s2] = 1'b0;
		next_b.ale = b.dma_s2 && b.dma_s3;
		unique case (b.phase)
			IOCH_IDLE:
			begin
				if (b.req_s2 != b.req_seen && b.mst_s2)
				begin
					next_b.req_seen = b.req_s2;
					next_b.cmd = req_cmd;
					next_b.addr = req_addr;
					next_b.wide = req_wide;
					next_b.sd_o = req_wdata;
					next_b.ale = 1'b1;
					next_b.phase = IOCH_ADDR;
				end
			end
			IOCH_ADDR:
			begin
				// Falling latch strobe captures the address
				next_b.sa = b.addr[`IOCH_SA_W-1:0];
				next_b.sbhe_n = ~b.wide;
				next_b.sd_oe = (b.cmd == `IOCH_CMD_IOW) || (b.cmd == `IOCH_CMD_MEMW);
				next_b.ior_n = ~(b.cmd == `IOCH_CMD_IOR);
				next_b.iow_n = ~(b.cmd == `IOCH_CMD_IOW);
				next_b.memr_n = ~(b.cmd == `IOCH_CMD_MEMR);
				next_b.memw_n = ~(b.cmd == `IOCH_CMD_MEMW);
				next_b.smemr_n = ~(b.cmd == `IOCH_CMD_MEMR && b.addr < `IOCH_LOW_MEG_LIMIT);
				next_b.smemw_n = ~(b.cmd == `IOCH_CMD_MEMW && b.addr < `IOCH_LOW_MEG_LIMIT);
				next_b.refresh_n = ~(b.cmd == `IOCH_CMD_REFR);
				next_b.wait_cnt = `IOCH_WAIT_8BIT;
				next_b.phase = IOCH_STROBE;
			end
			IOCH_STROBE:
			begin
				// Wait count chosen from the board's select lines
				if (!b.zws_s2)
					next_b.wait_cnt = `IOCH_WAIT_ZERO;
				else if ((!b.m16_s2 && b.cmd[1]) || (!b.i16_s2 && !b.cmd[1]))
					next_b.wait_cnt = `IOCH_WAIT_16BIT;
				next_b.phase = IOCH_WAIT;
			end
			IOCH_WAIT:
			begin
				if (!b.zws_s2 || b.wait_cnt == `IOCH_WAIT_ZERO)
				begin
					// Stretched while the board holds ready low
					if (b.rdy_s2)
						next_b.phase = IOCH_DONE;
				end
				else
					next_b.wait_cnt = b.wait_cnt - 3'h1;
			end
			IOCH_DONE:
			begin
				next_b.rdata = sd_i;
				next_b.ior_n = 1'b1;
				next_b.iow_n = 1'b1;
				next_b.memr_n = 1'b1;
				next_b.memw_n = 1'b1;
				next_b.smemr_n = 1'b1;
				next_b.smemw_n = 1'b1;
				next_b.refresh_n = 1'b1;
				next_b.sbhe_n = 1'b1;
				next_b.sd_oe = 1'b0;
				next_b.ack_tog = ~b.ack_tog;
				next_b.phase = IOCH_IDLE;
			end
		endcase
		if (b.rst_s2)
		begin
			next_b = '0;
			next_b.phase = IOCH_IDLE;
			// Reset, request and count synchronisers keep running; a request caught in reset is acknowledged with no cycle
			next_b.rst_s1 = s.bus_reset;
			next_b.rst_s2 = b.rst_s1;
			next_b.req_s1 = s.req_tog;
			next_b.req_s2 = b.req_s1;
			next_b.req_seen = b.req_s2;
			next_b.ack_tog = b.req_s2;
			next_b.tc_s1 = s.tc_tog;
			next_b.tc_s2 = b.tc_s1;
			next_b.tc_s3 = b.tc_s2;
			next_b.ior_n = 1'b1;
			next_b.iow_n = 1'b1;
			next_b.memr_n = 1'b1;
			next_b.memw_n = 1'b1;
			next_b.smemr_n = 1'b1;
			next_b.smemw_n = 1'b1;
			next_b.refresh_n = 1'b1;
			next_b.sbhe_n = 1'b1;
			next_b.dack_n = '1;
		end
	end

	// Bus side runs only on bus_clk, no phase relation to clk assumed
	always_ff @(posedge bus_clk)
		b <= next_b;

	// Output drivers straight from flops
	always_comb
	begin
		req_done = s.req_done;
		req_rdata = s.rdata;
		irq_pending = s.irq_pending;
		irq_vector = s.irq_vector;
		chan_err = s.chan_err;
		dma_grant_ch = s.dma_ch;
		dma_grant_wide = s.dma_wide;
		dma_active = s.dma_active;
		bus_reset = s.bus_reset;
		sa = b.sa;
		addr_latch = b.ale;
		sd_o = b.sd_o;
		sd_oe = b.sd_oe;
		ior_n = b.ior_n;
		iow_n = b.iow_n;
		smemr_n = b.smemr_n;
		smemw_n = b.smemw_n;
		memr_n = b.memr_n;
		memw_n = b.memw_n;
		refresh_n = b.refresh_n;
		sbhe_n = b.sbhe_n;
		addr_en = b.aen;
		term_count = b.tc;
		dack_n = b.dack_n;
	end
endmodule : ioch_host

// >>> design/ioch_params.svh
// Constants for the I/O channel host controller
// Notes on behaviour
// - System address lines 0..19 are caught on the falling edge of the latch strobe.
// - During DMA cycles the latch strobe stays high, never pulses.
// - Bus reset output is high during power-up, low line voltage, or hardware reset.
// - A board pulls ready low to stretch the cycle; host waits while low.
// - Interrupt ranking: 9,10,11,12,13,15,3,4,5,6,7 from highest to lowest.
// - Active-low I/O read makes the addressed board drive data for sampling.
// - Active-low I/O write makes the addressed board take the host data.
// - System memory strobes only below 1 MB; general memory strobes for any address.
// - DMA channels 0..3 move bytes, channels 5..7 move 16-bit words.
// - DMA requests served in fixed priority 0,1,2,3,5,6,7.
// - Each DMA channel gets its own active-low acknowledge line.
// - Address enable is high while DMA owns the bus, low for the processor.
// - Active-low refresh marks refresh cycles; a bus master may drive it too.
// - One terminal count pulse when any DMA channel reaches terminal count.
// - Bus high enable marks the upper data byte as valid.
// - Memory 16-bit select low gives a 16-bit cycle with one wait state.
// - I/O 16-bit select low gives a 16-bit cycle with one wait state.
// - Zero-wait-state line ends the present cycle without extra waits.
// - Channel check low reports a parity error, treated as an error event.
`ifndef IOCH_PARAMS_SVH
`define IOCH_PARAMS_SVH
`define IOCH_ADDR_W 24
`define IOCH_SA_W 20
`define IOCH_DATA_W 16
`define IOCH_LOW_MEG_LIMIT 24'h100000
`define IOCH_WAIT_8BIT 3'h4
`define IOCH_WAIT_16BIT 3'h1
`define IOCH_WAIT_ZERO 3'h0
`define IOCH_DMA_CH 8
`define IOCH_DMA_NONE 3'h4
`define IOCH_IRQ_N 16
`define IOCH_IRQ_NONE 4'h0
`define IOCH_CMD_IOR 3'h0
`define IOCH_CMD_IOW 3'h1
`define IOCH_CMD_MEMR 3'h2
`define IOCH_CMD_MEMW 3'h3
`define IOCH_CMD_REFR 3'h4
`define IOCH_REL_TIME_US 15
`define IOCH_MASTER_NS 15000
`endif

// >>> design/ioch_pkg.sv
// Types for the I/O channel host controller
package ioch_pkg;
	typedef logic [2:0] ioch_cmd_t;
	typedef enum logic [2:0] {IOCH_IDLE, IOCH_ADDR, IOCH_STROBE, IOCH_WAIT, IOCH_DONE} ioch_phase_t;
endpackage : ioch_pkg

// >>> tb/ioch_props.sv
// Port assertions for the I/O channel host
`timescale 1ns/1ps
module ioch_props (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic bus_clk, // Bus clock
	input wire logic bus_reset, // Bus reset
	input wire logic power_fail, // Power pin
	input wire logic addr_latch, // Latch
	input wire logic addr_en, // DMA owns bus
	input wire logic memr_n, // Mem read
	input wire logic memw_n, // Mem write
	input wire logic smemr_n, // Low read
	input wire logic smemw_n, // Low write
	input wire logic term_count, // Count end
	input wire logic [7:0] dack_n, // Acks
	input wire logic [15:0] irq, // Irq pins
	input wire logic [3:0] irq_vector, // Top irq
	input wire logic irq_pending, // Irq flag
	input wire logic iochck_n, // Check pin
	input wire logic chan_err // Error flag
);
	property p_latch;
		@(posedge bus_clk) disable iff (rst || bus_reset) addr_en |-> addr_latch;
	endproperty
	a_latch: assert property (p_latch) else $error("latch pulsed in DMA");
	property p_smemr;
		@(posedge bus_clk) disable iff (rst || bus_reset) !smemr_n |-> !memr_n;
	endproperty
	a_smemr: assert property (p_smemr) else $error("low read alone");
	property p_smemw;
		@(posedge bus_clk) disable iff (rst || bus_reset) !smemw_n |-> !memw_n;
	endproperty
	a_smemw: assert property (p_smemw) else $error("low write alone");
	property p_dack;
		@(posedge bus_clk) disable iff (rst || bus_reset) dack_n[4] && $onehot0(~dack_n);
	endproperty
	a_dack: assert property (p_dack) else $error("bad acknowledge");
	property p_tc;
		@(posedge bus_clk) disable iff (rst || bus_reset) term_count |=> !term_count;
	endproperty
	a_tc: assert property (p_tc) else $error("count pulse too long");
	property p_rst;
		@(posedge clk) disable iff (rst) (power_fail [*5] |-> bus_reset) and (!power_fail [*5] |-> !bus_reset);
	endproperty
	a_rst: assert property (p_rst) else $error("bus reset wrong");
	property p_chk;
		@(posedge clk) disable iff (rst) !iochck_n [*4] |-> chan_err;
	endproperty
	a_chk: assert property (p_chk) else $error("check missed");
	property p_irq;
		@(posedge clk) disable iff (rst) irq[9] [*4] |-> irq_pending && irq_vector == 4'h9;
	endproperty
	a_irq: assert property (p_irq) else $error("top irq wrong");
endmodule : ioch_props
bind ioch_host ioch_props u_props (.clk, .rst, .bus_clk, .bus_reset, .power_fail, .addr_latch, .addr_en, .memr_n,
	.memw_n, .smemr_n, .smemw_n, .term_count, .dack_n, .irq, .irq_vector, .irq_pending, .iochck_n, .chan_err);

// >>> tb/ioch_board.sv
// Plug-in board model: one data word, ready stretch, width and wait selects
`timescale 1ns/1ps
module ioch_board (
	input wire logic bus_clk, // Bus clock
	input wire logic rd_n, // Any read strobe
	input wire logic wr_n, // Any write strobe
	input wire logic [15:0] sd_o, // Host data
	input wire logic sd_oe, // Host drives data
	input wire logic [2:0] mode, // I/O 16, mem 16, zero wait
	input wire logic [3:0] slow, // Ready-low clocks
	output logic [15:0] sd_i, // Board data
	output logic iochrdy, // Ready
	output logic iocs16_n, // I/O 16 select
	output logic memcs16_n, // Mem 16 select
	output logic zws_n // Zero wait
);
	logic [15:0] word = 16'h0000;
	logic [15:0] last = 16'h0000;
	logic [3:0] cnt = 4'h0;
	logic act_q = 1'b0;
	wire act = !rd_n || !wr_n;
	// Open-collector selects, high unless asserted
	assign iocs16_n = !mode[0];
	assign memcs16_n = !mode[1];
	assign zws_n = !mode[2];
	// Ready held low from strobe start
	assign iochrdy = !(act && (act_q ? cnt != 4'h0 : slow != 4'h0));
	// Read data, else a pattern that flips every clock
	assign sd_i = !rd_n ? word : ~last;
	// Write capture and ready count
	always @(posedge bus_clk)
	begin
		act_q <= act;
		last <= sd_i;
		if (act && !act_q)
			cnt <= (slow == 4'h0) ? 4'h0 : slow - 4'h1;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		if (!wr_n && sd_oe)
			word <= sd_o;
	end
endmodule : ioch_board

// >>> tb/testbench.sv
// Self-checking bench for the I/O channel host
`timescale 1ns/1ps
`include "ioch_params.svh"
module testbench;
	import ioch_pkg::*;
	logic clk = 0, bus_clk = 0, rst = 1, power_fail = 0, req_valid = 0, req_wide = 0, dma_tc_in = 0;
	logic dma_done = 0, chan_err_clr = 0, iochck_n = 1, master_n = 1; // A board takes mastership only in t_master
	ioch_cmd_t req_cmd = 0;
	logic [23:0] req_addr = 0;
	logic [15:0] req_wdata = 0, irq = 0, req_rdata, sd_o, sd_i, rd;
	logic [7:0] drq = 0, dack_n;
	logic [3:0] slow = 0, irq_vector;
	logic [2:0] mode = 0, dma_grant_ch;
	logic [19:0] sa;
	logic req_done, irq_pending, chan_err, dma_grant_wide, dma_active, bus_reset, addr_latch, sd_oe, ior_n, iow_n;
	logic smemr_n, smemw_n, memr_n, memw_n, refresh_n, sbhe_n, addr_en, term_count, iochrdy, memcs16_n, iocs16_n;
	logic zws_n, saw_hi, saw_s, saw_r;
	int err_count = 0, comparisons = 0, cyc = 0, lcnt = 0, base = 0, tcn = 0;
	logic [2:0] ord [7] = '{0, 1, 2, 3, 5, 6, 7};
	logic [3:0] rank [11] = '{9, 10, 11, 12, 13, 15, 3, 4, 5, 6, 7};
	ioch_host u_dut (.clk, .rst, .bus_clk, .power_fail, .req_valid, .req_cmd, .req_addr, .req_wdata, .req_wide,
		.req_done, .req_rdata, .irq_pending, .irq_vector, .chan_err, .chan_err_clr, .dma_grant_ch, .dma_grant_wide,
		.dma_active, .dma_tc_in, .dma_done, .bus_reset, .sa, .addr_latch, .sd_o, .sd_oe, .sd_i, .ior_n, .iow_n,
		.smemr_n, .smemw_n, .memr_n, .memw_n, .refresh_n, .sbhe_n, .addr_en, .term_count, .dack_n, .drq, .irq,
		.iochrdy, .iochck_n, .memcs16_n, .iocs16_n, .zws_n, .master_n);
	ioch_board u_board (.bus_clk, .rd_n(ior_n && memr_n), .wr_n(iow_n && memw_n), .sd_o, .sd_oe, .mode, .slow,
		.sd_i, .iochrdy, .iocs16_n, .memcs16_n, .zws_n);
	// System clock, and a bus clock of unrelated phase
	always #10 clk = ~clk;
	initial
	begin
		#3.7;
		forever #6 bus_clk = ~bus_clk;
	end
	// Bus watch: strobe length, upper byte, low-meg strobes, count pulses
	always @(posedge bus_clk)
	begin
		if (!(ior_n && iow_n && memr_n && memw_n))
		begin
			lcnt <= lcnt + 1;
			saw_hi <= saw_hi | !sbhe_n;
		end
		saw_s <= saw_s | !smemr_n | !smemw_n;
		saw_r <= saw_r | !refresh_n;
		tcn <= tcn + int'(term_count);
	end
	// Hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			err_count++;
			end_sim;
		end
	end
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic do_req(input ioch_cmd_t c, input logic [23:0] a, input logic [15:0] d, input logic w);
		int n;
		lcnt = 0;
		saw_hi = 1'b0;
		saw_s = 1'b0;
		saw_r = 1'b0;
		{req_cmd, req_addr, req_wdata, req_wide, req_valid} = {c, a, d, w, 1'b1};
		for (n = 0; n < 300 && req_done !== 1'b1; n++)
			@(negedge clk);
		rd = req_rdata;
		req_valid = 1'b0;
		chk(n < 300 && sa === a[19:0], "cycle end or address");
		@(negedge clk);
	endtask : do_req
	task automatic t_xfer;
		do_req(`IOCH_CMD_IOW, 24'h000300, 16'hA55A, 1'b1);
		chk(saw_hi === 1'b1 && saw_r === 1'b0, "upper byte");
		do_req(`IOCH_CMD_IOR, 24'h000300, 16'h0000, 1'b1);
		chk(rd === 16'hA55A, "io read");
		do_req(`IOCH_CMD_MEMW, 24'h0FFFFF, 16'h1234, 1'b0);
		chk(saw_s === 1'b1 && saw_hi === 1'b0, "low meg");
		do_req(`IOCH_CMD_MEMR, 24'h100000, 16'h0000, 1'b0);
		chk(saw_s === 1'b0 && rd[7:0] === 8'h34, "above meg");
		do_req(`IOCH_CMD_REFR, 24'h000000, 16'h0000, 1'b0);
		chk(saw_r === 1'b1 && lcnt === 0 && saw_s === 1'b0, "refresh");
		$display("transfer test done");
	endtask : t_xfer
	// A held master signal keeps the host off the bus; the cycle runs once it is released
	task automatic t_master;
		master_n = 1'b0;
		lcnt = 0;
		{req_cmd, req_addr, req_wdata, req_wide, req_valid} = {`IOCH_CMD_IOW, 24'h000310, 16'h5AA5, 1'b0, 1'b1};
		repeat (20) @(negedge clk);
		chk(lcnt === 0 && req_done === 1'b0, "no cycle while mastered");
		master_n = 1'b1;
		do_req(`IOCH_CMD_IOW, 24'h000310, 16'h5AA5, 1'b0);
		do_req(`IOCH_CMD_IOR, 24'h000310, 16'h0000, 1'b1);
		chk(rd === 16'h5AA5, "write after release");
		$display("master test done");
	endtask : t_master
	task automatic t_wait;
		mode = 3'h4;
		do_req(`IOCH_CMD_IOR, 24'h000300, 16'h0000, 1'b0);
		base = lcnt;
		mode = 3'h1;
		do_req(`IOCH_CMD_IOR, 24'h000300, 16'h0000, 1'b1);
		chk(lcnt === base + 1, "io 16 wait");
		mode = 3'h2;
		do_req(`IOCH_CMD_MEMR, 24'h000300, 16'h0000, 1'b1);
		chk(lcnt === base + 1, "mem 16 wait");
		mode = 3'h0;
		do_req(`IOCH_CMD_IOR, 24'h000300, 16'h0000, 1'b0);
		chk(lcnt === base + 4, "byte wait");
		slow = 4'hC;
		do_req(`IOCH_CMD_IOR, 24'h000300, 16'h0000, 1'b0);
		chk(lcnt >= base + 12, "ready stretch");
		slow = 4'h0;
		$display("wait test done");
	endtask : t_wait
	task automatic t_dma;
		tcn = 0;
		drq = 8'hEF;
		foreach (ord[i])
		begin
			repeat (14) @(negedge clk);
			chk(dma_grant_ch === ord[i] && dma_grant_wide === (ord[i] > 3'h3) && dack_n === ~(8'h01 << ord[i])
				&& addr_en === 1'b1 && addr_latch === 1'b1, "dma grant");
			dma_tc_in = (i == 0);
			dma_done = 1'b1;
			drq[ord[i]] = 1'b0;
			@(negedge clk);
			{dma_tc_in, dma_done} = 2'b00;
		end
		repeat (14) @(negedge clk);
		chk(dma_active === 1'b0 && addr_en === 1'b0 && tcn === 1, "dma end");
		$display("dma test done");
	endtask : t_dma
	task automatic t_irq;
		irq = 16'hBEF8;
		foreach (rank[i])
		begin
			repeat (5) @(negedge clk);
			chk(irq_pending === 1'b1 && irq_vector === rank[i], "irq rank");
			irq[rank[i]] = 1'b0;
		end
		repeat (5) @(negedge clk);
		chk(irq_pending === 1'b0, "irq idle");
		$display("irq test done");
	endtask : t_irq
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	// Reset release, power fault, channel check
	task automatic t_reset;
		chk(bus_reset === 1'b1, "bus reset in reset");
		rst = 0;
		power_fail = 1;
		repeat (6) @(negedge clk);
		chk(bus_reset === 1'b1, "bus reset on power");
		power_fail = 0;
		iochck_n = 0;
		repeat (20) @(negedge clk);
		chk(bus_reset === 1'b0 && chan_err === 1'b1 && dack_n === 8'hFF && addr_en === 1'b0, "idle");
		iochck_n = 1;
		chan_err_clr = 1;
		repeat (4) @(negedge clk);
		chan_err_clr = 0;
		chk(chan_err === 1'b0, "error clear");
		$display("reset test done");
	endtask : t_reset
	// Reset held three cycles, then the scenarios
	initial
	begin
		repeat (3) @(negedge clk);
		t_reset;
		t_xfer;
		t_master;
		t_wait;
		t_dma;
		t_irq;
		end_sim;
	end
endmodule : testbench
